// ### design/dmba_bank_map.sv
// direct address former: bank select, access bank or full address
`timescale 1ns/1ps
`default_nettype none
module dmba_bank_map (
  // address sources
  input  wire logic [3:0]  bank,
  input  wire logic        access_bit,
  input  wire logic [7:0]  file_addr,
  input  wire logic        full_sel,
  input  wire logic [11:0] full_addr,
  // formed address
  output logic      [11:0] addr
);

  wire [3:0]  access_upper;
  wire [11:0] short_addr;

  // low file addresses land in bank 0, upper ones in the register bank
  assign access_upper = file_addr[7] ? dmba_pkg::SFR_BANK : dmba_pkg::LOW_BANK;
  assign short_addr   = access_bit ? {bank, file_addr} : {access_upper, file_addr};
  // the move between files carries its one 12-bit address whole
  assign addr         = full_sel ? full_addr : short_addr;

endmodule
`default_nettype wire

// ### design/dmba_pkg.sv
// constants, offsets and types shared by the data memory addressing unit
package dmba_pkg;

  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 8;
  localparam int          NUM_BANKS     = 16;
  localparam int          NUM_PTR       = 3;

  // access bank: low half from bank 0, high half from the register bank
  localparam logic [3:0]  LOW_BANK      = 4'h0;
  localparam logic [3:0]  SFR_BANK      = 4'hF;

  // implemented banks, one bit per bank
  localparam logic [15:0] BANK_IMPL_DEF = 16'h8003;

  // alias locations of each pointer, 8-aligned blocks in the register bank
  localparam logic [11:0] IND_BASE0     = 12'hFE8;
  localparam logic [11:0] IND_BASE1     = 12'hFE0;
  localparam logic [11:0] IND_BASE2     = 12'hFD8;

  // alias kinds, offset inside an alias block
  localparam logic [2:0]  IND_PLAIN      = 3'h0;
  localparam logic [2:0]  IND_AFTER_DOWN = 3'h1;
  localparam logic [2:0]  IND_AFTER_UP   = 3'h2;
  localparam logic [2:0]  IND_BEFORE_UP  = 3'h3;
  localparam logic [2:0]  IND_INDEXED    = 3'h4;

  // register port indices
  localparam logic [3:0]  REG_BANK_SELECT = 4'h0;
  localparam logic [3:0]  REG_WORKING_ACC = 4'h1;
  localparam logic [3:0]  REG_PTR0_LOW    = 4'h2;
  localparam logic [3:0]  REG_PTR0_HIGH   = 4'h3;
  localparam logic [3:0]  REG_LAST_LOW    = 4'h8;
  localparam logic [3:0]  REG_LAST_HIGH   = 4'h9;

  // reset values
  localparam logic [3:0]  BANK_RST      = 4'h0;
  localparam logic [7:0]  WACC_RST      = 8'h00;
  localparam logic [11:0] PTR_RST       = 12'h000;

  typedef enum logic [1:0] {
    OP_IDLE,
    OP_BANKED,
    OP_FULL,
    OP_LIT_BANK
  } dmba_op_type;

endpackage

// ### design/dmba_pointer.sv
// one indirect pointer with byte-wise load and whole-width step
`timescale 1ns/1ps
`default_nettype none
module dmba_pointer #(
  parameter int W = dmba_pkg::ADDR_W
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rstn,
  // byte loads from the register port
  input  wire logic         wr_low,
  input  wire logic         wr_high,
  input  wire logic [7:0]   wdata,
  // steps from indirect accesses
  input  wire logic         step_up,
  input  wire logic         step_down,
  // pointer value
  output logic      [W-1:0] ptr
);

  logic [W-1:0] ptr_reg;
  wire  [W-1:0] stepped;
  wire  [W-1:0] ptr_next;

  // full-width add so the low byte carries into the high part
  assign stepped  = step_up ? ptr_reg + W'(1) :
                    step_down ? ptr_reg - W'(1) : ptr_reg;
  // a load wins over a step for the byte it touches; extra high bits are dropped
  assign ptr_next = {wr_high ? wdata[W-9:0] : stepped[W-1:8],
                     wr_low ? wdata : stepped[7:0]};
  assign ptr      = ptr_reg;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ptr_reg <= dmba_pkg::PTR_RST;
    end else begin
      ptr_reg <= ptr_next;
    end
  end

endmodule
`default_nettype wire

// ### design/dmba_top.sv
// data memory bank addressing unit: direct, access bank and indirect addressing
//
// Contract
// - data memory is split into sixteen banks and the bank select value picks the bank.
// - the low four bank select bits are the top four bits of a banked 12-bit address.
// - the upper four bank select bits read as zero and writes to them are lost.
// - the access bank is the low 128 bytes of bank 0 plus the high 128 bytes of bank 15.
// - the access bit of a file instruction picks the selected bank or the access bank.
// - with the access bit zero the access bank is one seamless 256-byte window.
// - the upper access half reaches the special function registers with no bank change.
// - an unimplemented bank reads as zero and ignores writes.
// - accesses to an unimplemented bank still let the status flags update.
// - each bank spans file addresses 00h to FFh from the 8-bit address field.
// - the file-to-file move uses full 12-bit addresses and ignores the bank select.
// - the move-literal-to-bank instruction loads the bank select from its literal.
// - each of three pointers holds a 12-bit address reached through its alias.
// - each pointer has plain, post-decrement, post-increment, pre-increment and indexed aliases.
// - pointer steps carry across all 12 bits and leave the status flags alone.
// - an indirect access that lands on an alias reads 00h setting zero, or writes as a no-op.
`timescale 1ns/1ps
`default_nettype none
module dmba_top #(
  parameter logic [15:0] BANK_IMPL = dmba_pkg::BANK_IMPL_DEF
) (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 rstn,
  // request from the instruction decoder
  input  wire dmba_pkg::dmba_op_type op_kind,
  input  wire logic                 op_write,
  input  wire logic                 op_access_bit,
  input  wire logic [7:0]           op_file_addr,
  input  wire logic [11:0]          op_full_addr,
  input  wire logic [7:0]           op_wdata,
  input  wire logic [7:0]           op_literal,
  // result back to the core
  output logic                      res_valid,
  output logic                      res_read,
  output logic [7:0]                res_rdata,
  output logic                      res_flags_en,
  output logic                      res_zero_set,
  // static data RAM
  output logic [11:0]               ram_addr,
  output logic                      ram_rd,
  output logic                      ram_wr,
  output logic [7:0]                ram_wdata,
  input  wire logic [7:0]           ram_rdata,
  // software register port
  input  wire logic [3:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [7:0]                reg_rdata
);

  localparam int NP = dmba_pkg::NUM_PTR;

  ////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic [11:0] alias_base(input int n);
    alias_base = (n == 0) ? dmba_pkg::IND_BASE0 :
                 (n == 1) ? dmba_pkg::IND_BASE1 : dmba_pkg::IND_BASE2;
  endfunction

  // address is one of the five alias slots of pointer n
  function automatic logic alias_hit(input logic [11:0] a, input int n);
    logic [11:0] b;
    b         = alias_base(n);
    alias_hit = (a[11:3] == b[11:3]) && (a[2:0] <= dmba_pkg::IND_INDEXED);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [3:0]  bank_reg;
  logic [7:0]  wacc_reg;
  logic [11:0] last_addr_reg;
  logic        last_unimpl_reg;
  logic        last_loop_reg;

  // pipeline toward the RAM and the result
  logic [11:0] ram_addr_reg;
  logic        ram_rd_reg;
  logic        ram_wr_reg;
  logic [7:0]  ram_wdata_reg;
  logic        s1_valid_reg;
  logic        s1_read_reg;
  logic        s1_kill_reg;
  logic        s1_loop_reg;
  logic        s2_valid_reg;
  logic        s2_read_reg;
  logic        s2_kill_reg;
  logic        s2_loop_reg;
  logic        res_valid_reg;
  logic        res_read_reg;
  logic [7:0]  res_rdata_reg;
  logic        res_flags_en_reg;
  logic        res_zero_set_reg;
  logic [7:0]  reg_rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // direct address

  wire        op_data;
  wire        op_full;
  wire        op_lit;
  wire [11:0] dir_addr;

  assign op_data = (op_kind == dmba_pkg::OP_BANKED) || (op_kind == dmba_pkg::OP_FULL);
  assign op_full = (op_kind == dmba_pkg::OP_FULL);
  assign op_lit  = (op_kind == dmba_pkg::OP_LIT_BANK);

  dmba_bank_map u_map (
    .bank       (bank_reg),
    .access_bit (op_access_bit),
    .file_addr  (op_file_addr),
    .full_sel   (op_full),
    .full_addr  (op_full_addr),
    .addr       (dir_addr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // indirect pointers

  wire [2:0]  ind_kind;
  wire [NP-1:0] hit;
  wire [11:0] ptr_val [NP];

  assign ind_kind = dir_addr[2:0];

  for (genvar g = 0; g < NP; g++) begin : g_ptr
    wire [3:0] low_idx;
    wire [3:0] high_idx;
    wire       up;
    wire       down;

    assign low_idx  = dmba_pkg::REG_PTR0_LOW + 4'(2 * g);
    assign high_idx = dmba_pkg::REG_PTR0_HIGH + 4'(2 * g);
    assign hit[g]   = op_data && alias_hit(dir_addr, g);
    assign up       = hit[g] && ((ind_kind == dmba_pkg::IND_AFTER_UP) ||
                                 (ind_kind == dmba_pkg::IND_BEFORE_UP));
    assign down     = hit[g] && (ind_kind == dmba_pkg::IND_AFTER_DOWN);

    dmba_pointer #(
      .W (dmba_pkg::ADDR_W)
    ) u_ptr (
      .clock     (clock),
      .rstn      (rstn),
      .wr_low    (reg_wr && (reg_addr == low_idx)),
      .wr_high   (reg_wr && (reg_addr == high_idx)),
      .wdata     (reg_wdata),
      .step_up   (up),
      .step_down (down),
      .ptr       (ptr_val[g])
    );
  end

  wire        is_ind;
  wire [11:0] sel_ptr;
  wire [11:0] index_ext;
  wire [11:0] ind_addr;

  assign is_ind    = |hit;
  assign sel_ptr   = hit[0] ? ptr_val[0] : hit[1] ? ptr_val[1] : ptr_val[2];
  // the accumulator is a signed offset; neither it nor the pointer changes
  assign index_ext = {{4{wacc_reg[7]}}, wacc_reg};
  assign ind_addr  = (ind_kind == dmba_pkg::IND_BEFORE_UP) ? sel_ptr + 12'h001 :
                     (ind_kind == dmba_pkg::IND_INDEXED) ? sel_ptr + index_ext :
                     sel_ptr;

  ////////////////////////////////////////////////////////////////////////////
  // effective address and access checks

  wire [11:0] eff_addr;
  wire        loop_hit;
  wire        unimpl;
  wire        kill;

  assign eff_addr = is_ind ? ind_addr : dir_addr;
  // a pointer aimed back at an alias block never reaches the RAM
  assign loop_hit = is_ind && (alias_hit(eff_addr, 0) || alias_hit(eff_addr, 1) ||
                               alias_hit(eff_addr, 2));
  assign unimpl   = !BANK_IMPL[eff_addr[11:8]];
  assign kill     = loop_hit || unimpl;

  ////////////////////////////////////////////////////////////////////////////
  // bank select and accumulator

  wire [3:0] bank_next;
  wire [7:0] wacc_next;

  // the instruction load wins over a software write in the same cycle
  assign bank_next = op_lit ? op_literal[3:0] :
                     (reg_wr && reg_addr == dmba_pkg::REG_BANK_SELECT) ? reg_wdata[3:0] :
                     bank_reg;
  assign wacc_next = (reg_wr && reg_addr == dmba_pkg::REG_WORKING_ACC) ? reg_wdata : wacc_reg;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bank_reg <= dmba_pkg::BANK_RST;
      wacc_reg <= dmba_pkg::WACC_RST;
    end else begin
      bank_reg <= bank_next;
      wacc_reg <= wacc_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // RAM request stage

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ram_addr_reg  <= 12'h000;
      ram_rd_reg    <= 1'b0;
      ram_wr_reg    <= 1'b0;
      ram_wdata_reg <= 8'h00;
      s1_valid_reg  <= 1'b0;
      s1_read_reg   <= 1'b0;
      s1_kill_reg   <= 1'b0;
      s1_loop_reg   <= 1'b0;
    end else begin
      ram_addr_reg  <= op_data ? eff_addr : ram_addr_reg;
      ram_rd_reg    <= op_data && !op_write && !kill;
      ram_wr_reg    <= op_data && op_write && !kill;
      ram_wdata_reg <= op_data ? op_wdata : ram_wdata_reg;
      s1_valid_reg  <= op_data;
      s1_read_reg   <= !op_write;
      s1_kill_reg   <= kill;
      s1_loop_reg   <= loop_hit;
    end
  end

  // RAM answers in the cycle after its read strobe
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s2_valid_reg <= 1'b0;
      s2_read_reg  <= 1'b0;
      s2_kill_reg  <= 1'b0;
      s2_loop_reg  <= 1'b0;
    end else begin
      s2_valid_reg <= s1_valid_reg;
      s2_read_reg  <= s1_read_reg;
      s2_kill_reg  <= s1_kill_reg;
      s2_loop_reg  <= s1_loop_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result stage

  wire [7:0] res_data_next;
  wire       flags_next;

  assign res_data_next = (s2_read_reg && !s2_kill_reg) ? ram_rdata : 8'h00;
  // unimplemented banks keep normal flag behaviour; an alias-loop write does not
  assign flags_next    = s2_read_reg || !s2_loop_reg;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      res_valid_reg    <= 1'b0;
      res_read_reg     <= 1'b0;
      res_rdata_reg    <= 8'h00;
      res_flags_en_reg <= 1'b0;
      res_zero_set_reg <= 1'b0;
    end else begin
      res_valid_reg    <= s2_valid_reg;
      res_read_reg     <= s2_valid_reg && s2_read_reg;
      res_rdata_reg    <= res_data_next;
      res_flags_en_reg <= s2_valid_reg && flags_next;
      res_zero_set_reg <= s2_valid_reg && s2_read_reg && s2_loop_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // last access status and register read port

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      last_addr_reg   <= 12'h000;
      last_unimpl_reg <= 1'b0;
      last_loop_reg   <= 1'b0;
    end else if (op_data) begin
      last_addr_reg   <= eff_addr;
      last_unimpl_reg <= unimpl;
      last_loop_reg   <= loop_hit;
    end
  end

  wire [7:0] rd_mux;
  wire [2:0] rd_ptr;

  assign rd_ptr = 3'((reg_addr - dmba_pkg::REG_PTR0_LOW) >> 1);
  assign rd_mux =
    (reg_addr == dmba_pkg::REG_BANK_SELECT) ? {4'h0, bank_reg} :
    (reg_addr == dmba_pkg::REG_WORKING_ACC) ? wacc_reg :
    (reg_addr == dmba_pkg::REG_LAST_LOW)    ? last_addr_reg[7:0] :
    (reg_addr == dmba_pkg::REG_LAST_HIGH)   ? {2'h0, last_loop_reg, last_unimpl_reg,
                                               last_addr_reg[11:8]} :
    (reg_addr < dmba_pkg::REG_PTR0_LOW || rd_ptr >= 3'(NP)) ? 8'h00 :
    reg_addr[0] ? {4'h0, ptr_val[rd_ptr[1:0]][11:8]} : ptr_val[rd_ptr[1:0]][7:0];

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_reg <= 8'h00;
    end else begin
      reg_rdata_reg <= reg_rd ? rd_mux : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign ram_addr     = ram_addr_reg;
  assign ram_rd       = ram_rd_reg;
  assign ram_wr       = ram_wr_reg;
  assign ram_wdata    = ram_wdata_reg;
  assign res_valid    = res_valid_reg;
  assign res_read     = res_read_reg;
  assign res_rdata    = res_rdata_reg;
  assign res_flags_en = res_flags_en_reg;
  assign res_zero_set = res_zero_set_reg;
  assign reg_rdata    = reg_rdata_reg;

endmodule
`default_nettype wire

// ### verification/dmba_ram_model.sv
// static data RAM behind the unit: read data stand only in the cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module dmba_ram_model (
  // clock
  input  wire logic        clock,
  // strobes from the unit
  input  wire logic [11:0] ram_addr,
  input  wire logic        ram_rd,
  input  wire logic        ram_wr,
  input  wire logic [7:0]  ram_wdata,
  // read data
  output logic      [7:0]  ram_rdata
);
  logic [7:0] mem [0:4095];

  initial ram_rdata = 8'hA5;

  // stale data is inverted every cycle so a sample one cycle late never matches
  always @(posedge clock) begin
    if (ram_wr)
      mem[ram_addr] <= ram_wdata;
    if (ram_rd)
      ram_rdata <= mem[ram_addr];
    else
      ram_rdata <= ~ram_rdata;
  end
endmodule
`default_nettype wire

// ### verification/dmba_top_props.sv
// concurrent checks on the ports of the data memory addressing unit
`timescale 1ns/1ps
`default_nettype none
module dmba_props #(
  parameter logic [15:0] BANK_IMPL = 16'h8003
) (
  // clock and reset
  input wire logic                  clock,
  input wire logic                  rstn,
  // decoder request
  input wire dmba_pkg::dmba_op_type op_kind,
  input wire logic                  op_write,
  input wire logic                  op_access_bit,
  input wire logic [7:0]            op_file_addr,
  input wire logic [11:0]           op_full_addr,
  input wire logic [7:0]            op_wdata,
  input wire logic [7:0]            op_literal,
  // result
  input wire logic                  res_valid,
  input wire logic                  res_read,
  input wire logic [7:0]            res_rdata,
  input wire logic                  res_flags_en,
  input wire logic                  res_zero_set,
  // data RAM
  input wire logic [11:0]           ram_addr,
  input wire logic                  ram_rd,
  input wire logic                  ram_wr,
  input wire logic [7:0]            ram_wdata,
  input wire logic [7:0]            ram_rdata,
  // register port
  input wire logic [3:0]            reg_addr,
  input wire logic [7:0]            reg_wdata,
  input wire logic                  reg_wr,
  input wire logic                  reg_rd,
  input wire logic [7:0]            reg_rdata
);
  logic       [3:0] bank_sh;
  wire logic        banked = op_kind == dmba_pkg::OP_BANKED;
  wire logic        full   = op_kind == dmba_pkg::OP_FULL;
  wire logic        strobe = ram_rd || ram_wr;

  // shadow of the bank select; the literal move wins over a same-cycle port write
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn)
      bank_sh <= 4'h0;
    else if (op_kind == dmba_pkg::OP_LIT_BANK)
      bank_sh <= op_literal[3:0];
    else if (reg_wr && reg_addr == 4'h0)
      bank_sh <= reg_wdata[3:0];
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  ////////////////////////////////////////////////////////////////////////////////
  sequence low_read_walk;
    ram_rd && !ram_wr && ram_addr == {4'h0, $past(op_file_addr)}
      ##2 res_valid && res_read && res_flags_en && !res_zero_set;
  endsequence

  sequence full_write_walk;
    ram_wr && !ram_rd && ram_wdata == $past(op_wdata)
      ##2 res_valid && !res_read && res_rdata == 8'h00;
  endsequence

  answer_latency_a: assert property ((banked || full) |-> ##3 res_valid)
    else $error("no result three cycles after a data request");
  access_low_a: assert property (banked && !op_write && !op_access_bit && !op_file_addr[7]
    |-> ##1 low_read_walk)
    else $error("access bank low half read went wrong");
  access_high_a: assert property (banked && !op_access_bit &&
    (op_file_addr[7:6] == 2'b10 || op_file_addr[7:4] == 4'hF)
    |-> ##1 strobe && ram_addr == {4'hF, $past(op_file_addr)})
    else $error("access bank high half not mapped to the register bank");
  banked_addr_a: assert property (banked && op_access_bit && BANK_IMPL[bank_sh] && bank_sh != 4'hF
    |-> ##1 strobe && ram_addr == {$past(bank_sh), $past(op_file_addr)})
    else $error("banked address does not use the bank select");
  unimpl_bank_a: assert property (banked && op_access_bit && !BANK_IMPL[bank_sh]
    |-> ##1 !strobe ##2 res_valid && res_rdata == 8'h00 && res_flags_en)
    else $error("unimplemented bank access reached the RAM");
  full_addr_a: assert property (full && op_full_addr[11:9] == 3'b000
    |-> ##1 strobe && ram_addr == $past(op_full_addr))
    else $error("full address move not taken as given");
  full_write_a: assert property (full && op_write && op_full_addr[11:9] == 3'b000
    |-> ##1 full_write_walk)
    else $error("full address write data or result wrong");
  bank_read_a: assert property (reg_rd && reg_addr == 4'h0
    |=> reg_rdata == {4'h0, $past(bank_sh)})
    else $error("bank select read back wrong");
  zero_set_a: assert property (res_zero_set
    |-> res_valid && res_read && res_rdata == 8'h00)
    else $error("zero set outside an alias loop read");
  flags_hold_a: assert property (res_valid && !res_flags_en
    |-> !res_read && !res_zero_set)
    else $error("flags held back on something other than an alias loop write");
endmodule
`default_nettype wire

// ### verification/testbench.sv
// self-checking bench of the data memory addressing unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam dmba_pkg::dmba_op_type K_BANKED = dmba_pkg::OP_BANKED;
  localparam dmba_pkg::dmba_op_type K_FULL   = dmba_pkg::OP_FULL;
  localparam logic [15:0]           IMPL     = dmba_pkg::BANK_IMPL_DEF;
  logic                  clock;
  logic                  rstn;
  dmba_pkg::dmba_op_type op_kind;
  logic                  op_write;
  logic                  op_access_bit;
  logic [7:0]            op_file_addr;
  logic [11:0]           op_full_addr;
  logic [7:0]            op_wdata;
  logic [7:0]            op_literal;
  logic                  res_valid;
  logic                  res_read;
  logic [7:0]            res_rdata;
  logic                  res_flags_en;
  logic                  res_zero_set;
  logic [11:0]           ram_addr;
  logic                  ram_rd;
  logic                  ram_wr;
  logic [7:0]            ram_wdata;
  logic [7:0]            ram_rdata;
  logic [3:0]            reg_addr;
  logic [7:0]            reg_wdata;
  logic                  reg_wr;
  logic                  reg_rd;
  logic [7:0]            reg_rdata;
  int                    num_errors;
  int                    cmp_count;
  integer                seed;
  logic                  rd_d;
  logic [7:0]            d0;
  logic [7:0]            d1;
  logic [7:0]            fa;
  logic [23:0]           ram_q[$];
  logic [10:0]           res_q[$];
  logic [7:0]            reg_q[$];

  dmba_top #(.BANK_IMPL(IMPL)) u_dmba_top (.clock(clock), .rstn(rstn), .op_kind(op_kind),
    .op_write(op_write), .op_access_bit(op_access_bit), .op_file_addr(op_file_addr),
    .op_full_addr(op_full_addr), .op_wdata(op_wdata), .op_literal(op_literal),
    .res_valid(res_valid), .res_read(res_read), .res_rdata(res_rdata),
    .res_flags_en(res_flags_en), .res_zero_set(res_zero_set), .ram_addr(ram_addr),
    .ram_rd(ram_rd), .ram_wr(ram_wr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  dmba_ram_model u_dmba_ram_model (.clock(clock), .ram_addr(ram_addr), .ram_rd(ram_rd),
    .ram_wr(ram_wr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    if (ram_q.size() != 0 || res_q.size() != 0 || reg_q.size() != 0)
      num_errors++;
    $display("comparisons %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    reg_q.push_back(e);
    @(posedge clock);
    reg_rd   <= 1'b0;
  endtask

  task automatic lit_bank(input logic [7:0] v);
    @(posedge clock);
    op_kind    <= dmba_pkg::OP_LIT_BANK;
    op_literal <= v;
  endtask
  task automatic idle();
    @(posedge clock);
    op_kind <= dmba_pkg::OP_IDLE;
  endtask
  // no idle between calls, so consecutive calls give back-to-back requests
  task automatic data_op(input dmba_pkg::dmba_op_type k, input logic w, input logic ab,
                         input logic [11:0] a, input logic [7:0] wd, input logic hit,
                         input logic [11:0] ea, input logic [7:0] rd, input logic [1:0] fz);
    @(posedge clock);
    op_kind       <= k;
    op_write      <= w;
    op_access_bit <= ab;
    op_file_addr  <= a[7:0];
    op_full_addr  <= a;
    op_wdata      <= wd;
    if (hit)
      ram_q.push_back({2'b00, ~w, w, ea, w ? wd : 8'h00});
    res_q.push_back({~w, fz, rd});
  endtask

  always @(posedge clock) begin
    if (rd_d)
      check({16'h0000, reg_rdata}, {16'h0000, reg_q.pop_front()});
    if (ram_rd || ram_wr)
      check({2'b00, ram_rd, ram_wr, ram_addr, ram_wr ? ram_wdata : 8'h00}, ram_q.pop_front());
    if (res_valid)
      check({13'h0000, res_read, res_flags_en, res_zero_set, res_rdata}, {13'h0000, res_q.pop_front()});
    rd_d <= reg_rd;
  end

  initial begin
    repeat (5000) @(posedge clock);
    num_errors++;
    give_verdict();
  end

  initial begin
    seed = 32'hFBE82385;
    num_errors = 0;
    cmp_count = 0;
    rd_d = 1'b0;
    rstn = 1'b0;
    op_kind = dmba_pkg::OP_IDLE;
    {op_write, op_access_bit, op_file_addr, op_full_addr, op_wdata, op_literal} = '0;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    for (int i = 0; i < 11; i++)
      reg_read(4'(i), 8'h00);
    reg_write(4'h0, 8'hFF);
    reg_read(4'h0, 8'h0F);
    reg_write(4'hA, 8'h55);
    reg_read(4'hA, 8'h00);
    // every bank: literal load, then a write and a read straight after it
    for (int b = 0; b < 16; b++) begin
      fa = {2'b01, 6'($random(seed))};
      d0 = 8'($random(seed));
      lit_bank({4'($random(seed)), 4'(b)});
      data_op(K_BANKED, '1, '1, {4'h0, fa}, d0, IMPL[b], {4'(b), fa}, 8'h00, 2'b10);
      data_op(K_BANKED, '0, '1, {4'h0, fa}, 8'h00, IMPL[b], {4'(b), fa}, IMPL[b] ? d0 : 8'h00, 2'b10);
      idle();
      reg_read(4'h0, {4'h0, 4'(b)});
    end
    d0 = 8'($random(seed));
    d1 = 8'($random(seed));
    lit_bank(8'h01);
    data_op(K_BANKED, '1, '1, 12'h000, 8'h11, '1, 12'h100, 8'h00, 2'b10);
    data_op(K_BANKED, '1, '1, 12'h0FF, 8'h22, '1, 12'h1FF, 8'h00, 2'b10);
    data_op(K_BANKED, '1, '0, 12'h07F, 8'h33, '1, 12'h07F, 8'h00, 2'b10);
    data_op(K_BANKED, '1, '0, 12'h080, 8'h44, '1, 12'hF80, 8'h00, 2'b10);
    data_op(K_FULL, '0, '1, 12'h1FF, 8'h00, '1, 12'h1FF, 8'h22, 2'b10);
    data_op(K_BANKED, '0, '0, 12'h07F, 8'h00, '1, 12'h07F, 8'h33, 2'b10);
    data_op(K_FULL, '0, '0, 12'hF80, 8'h00, '1, 12'hF80, 8'h44, 2'b10);
    data_op(K_FULL, '1, '0, 12'h0FF, d0, '1, 12'h0FF, 8'h00, 2'b10);
    data_op(K_FULL, '1, '0, 12'h100, d1, '1, 12'h100, 8'h00, 2'b10);
    idle();
    for (int p = 0; p < 3; p++) begin
      reg_write(4'(2 + 2 * p), 8'hFF);
      reg_write(4'(3 + 2 * p), 8'hF0);
      reg_read(4'(3 + 2 * p), 8'h00);
      data_op(K_BANKED, '0, '0, 12'(12'h0E8 - 8 * p), 8'h00, '1, 12'h0FF, d0, 2'b10);
      idle();
    end
    data_op(K_BANKED, '0, '0, 12'h0EA, 8'h00, '1, 12'h0FF, d0, 2'b10);
    data_op(K_BANKED, '0, '0, 12'h0EA, 8'h00, '1, 12'h100, d1, 2'b10);
    idle();
    reg_read(4'h2, 8'h01);
    reg_read(4'h3, 8'h01);
    data_op(K_BANKED, '1, '0, 12'h0E9, 8'h5C, '1, 12'h101, 8'h00, 2'b10);
    data_op(K_BANKED, '0, '0, 12'h0E8, 8'h00, '1, 12'h100, d1, 2'b10);
    data_op(K_BANKED, '0, '0, 12'h0EB, 8'h00, '1, 12'h101, 8'h5C, 2'b10);
    idle();
    reg_write(4'h1, 8'hFE);
    data_op(K_BANKED, '0, '0, 12'h0EC, 8'h00, '1, 12'h0FF, d0, 2'b10);
    idle();
    reg_read(4'h2, 8'h01);
    reg_read(4'h1, 8'hFE);
    // pointer aimed at its own alias block
    reg_write(4'h2, 8'hE8);
    reg_write(4'h3, 8'h0F);
    data_op(K_BANKED, '0, '0, 12'h0E8, 8'h00, '0, 12'h000, 8'h00, 2'b11);
    data_op(K_BANKED, '1, '0, 12'h0E8, 8'h77, '0, 12'h000, 8'h00, 2'b00);
    idle();
    reg_read(4'h8, 8'hE8);
    reg_read(4'h9, 8'h2F);
    repeat (2) @(posedge clock);
    give_verdict();
  end
endmodule

bind dmba_top dmba_props #(.BANK_IMPL(BANK_IMPL)) u_dmba_props (.clock(clock), .rstn(rstn),
  .op_kind(op_kind), .op_write(op_write), .op_access_bit(op_access_bit),
  .op_file_addr(op_file_addr), .op_full_addr(op_full_addr), .op_wdata(op_wdata),
  .op_literal(op_literal), .res_valid(res_valid), .res_read(res_read),
  .res_rdata(res_rdata), .res_flags_en(res_flags_en), .res_zero_set(res_zero_set),
  .ram_addr(ram_addr), .ram_rd(ram_rd), .ram_wr(ram_wr), .ram_wdata(ram_wdata),
  .ram_rdata(ram_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata));
`default_nettype wire
